// *** design/sdc_core.sv ***
// Purpose: decimation filter, conversion sequencer and result buffer of the converter back end
// Assumes: clk is the internal oscillator; modBit is valid at every fourth period
// Notes: results leave through a buffer with valid/ready so the serial side can cross safely
`timescale 1ns/1ns
`include "sdc_map.svh"

// result buffer with a registered head word
module sdc_fifo #(
    parameter int WIDTH = 24,
    parameter int DEPTH = 32
) (
    // clock and reset
    input wire logic clk,
    input wire logic resetn,
    // fill side
    input wire logic inValid,
    output logic inReady,
    input wire logic [WIDTH-1:0] inData,
    // drain side
    output logic outValid,
    input wire logic outReady,
    output logic [WIDTH-1:0] outData
);
    localparam int AW = $clog2(DEPTH);

    logic [WIDTH-1:0] mem [DEPTH];
    logic [AW-1:0] wrPtr_reg, wrPtr_next, rdPtr_reg, rdPtr_next;
    logic [AW:0] count_reg, count_next;
    logic outValid_reg, outValid_next;
    logic [WIDTH-1:0] outData_reg, outData_next;
    logic push, load;

    // pointer, level and head-word update
    always_comb begin
        inReady = count_reg != (AW+1)'(DEPTH);
        push = inValid && inReady;
        load = (count_reg != '0) && (!outValid_reg || outReady);
        wrPtr_next = push ? wrPtr_reg + 1'b1 : wrPtr_reg;
        rdPtr_next = load ? rdPtr_reg + 1'b1 : rdPtr_reg;
        count_next = count_reg + (AW+1)'(push) - (AW+1)'(load);
        outValid_next = load ? 1'b1 : (outReady ? 1'b0 : outValid_reg);
        outData_next = load ? mem[rdPtr_reg] : outData_reg;
    end

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            wrPtr_reg <= '0;
            rdPtr_reg <= '0;
            count_reg <= '0;
            outValid_reg <= 1'b0;
            outData_reg <= '0;
        end else begin
            wrPtr_reg <= wrPtr_next;
            rdPtr_reg <= rdPtr_next;
            count_reg <= count_next;
            outValid_reg <= outValid_next;
            outData_reg <= outData_next;
        end
    end

    // storage array, no reset needed
    always_ff @(posedge clk) begin
        if (push) begin
            mem[wrPtr_reg] <= inData;
        end
    end

    assign outValid = outValid_reg;
    assign outData = outData_reg;

    chk_fifo_full_stall: assert property (@(posedge clk) disable iff (!resetn)
        (count_reg == (AW+1)'(DEPTH)) |-> !inReady && (count_next <= count_reg))
        else $error("buffer accepted a word while full");
endmodule : sdc_fifo

// conversion core top
module sdc_conversion_core #(
    parameter sdc_pkg::sdc_variant_t VARIANT = sdc_pkg::SDC_VDUAL,
    parameter int CONV_PERIODS = sdc_pkg::conv_periods(VARIANT),
    parameter int FIFO_DEPTH = 32
) (
    // clock and reset
    input wire logic clk,
    input wire logic resetn,
    // conversion control, low enable means shutdown
    input wire logic convEnable,
    input wire logic contMode,
    // modulator stream
    input wire logic modBit,
    output logic modClk,
    // status
    output logic sharedDataDonePinN,
    output logic busy,
    // result words toward serial logic
    output logic resultValid,
    input wire logic resultReady,
    output sdc_pkg::sdc_word_t resultData
);
    localparam int NBITS = CONV_PERIODS / `SDC_BIT_DIV;
    // wide enough for the start-up extension too, which can outlast a short conversion
    localparam int PW = $clog2((CONV_PERIODS > `SDC_START_EXTRA) ? CONV_PERIODS : `SDC_START_EXTRA) + 1;
    localparam int ACC_W = 48;
    localparam int SHIFT = `SDC_ORDER * $clog2(NBITS) - 8 - (`SDC_CODE_W - 1) + `SDC_GAIN_SHIFT;
    localparam int SEG [`SDC_ORDER] = '{sdc_pkg::seg_len(VARIANT, 0, NBITS),
        sdc_pkg::seg_len(VARIANT, 1, NBITS), sdc_pkg::seg_len(VARIANT, 2, NBITS),
        sdc_pkg::seg_len(VARIANT, 3, NBITS)};

    // impulse of the fourth difference of the weight at bit idx
    function automatic logic signed [31:0] imp_at(input logic [PW-1:0] idx);
        int sum;
        logic neg;
        logic signed [31:0] r;
        r = '0;
        for (int s = 0; s < 16; s++) begin
            sum = 0;
            neg = 1'b0;
            for (int k = 0; k < `SDC_ORDER; k++) begin
                if (s[k]) begin
                    sum += SEG[k];
                    neg = ~neg;
                end
            end
            if (idx == PW'(sum)) begin
                r = neg ? r - 32'sd1 : r + 32'sd1;
            end
        end
        return r;
    endfunction : imp_at

    // scaled code with overrange flags and 23-bit clamp
    function automatic sdc_pkg::sdc_word_t make_word(input logic signed [ACC_W-1:0] acc);
        logic signed [63:0] sc;
        sdc_pkg::sdc_word_t w;
        sc = (64'(acc) * 64'sd`SDC_GAIN_NUM) >>> SHIFT;
        w.overrange_high_bit = sc > 64'sd2097151;
        w.overrange_low_bit = sc < -64'sd2097152;
        if (sc > 64'sd4194303) begin
            sc = 64'sd4194303;
        end else if (sc < -64'sd4194304) begin
            sc = -64'sd4194304;
        end
        w.code = sc[`SDC_CODE_W-1:0];
        return w;
    endfunction : make_word

    sdc_pkg::sdc_state_t state_reg, state_next;
    logic [PW-1:0] period_reg, period_next, bitIdx_reg, bitIdx_next;
    logic signed [ACC_W-1:0] acc_reg, acc_next;
    logic signed [31:0] d3_reg, d3_next, d2_reg, d2_next, d1_reg, d1_next, w_reg, w_next;
    logic doneN_reg, doneN_next, modClk_reg, modClk_next, busy_reg, busy_next;
    logic push, fifoInReady;
    sdc_pkg::sdc_word_t word;

    // sequencer and filter datapath
    always_comb begin
        state_next = state_reg;
        period_next = period_reg;
        bitIdx_next = bitIdx_reg;
        acc_next = acc_reg;
        d3_next = d3_reg;
        d2_next = d2_reg;
        d1_next = d1_reg;
        w_next = w_reg;
        doneN_next = doneN_reg;
        push = 1'b0;
        word = make_word(acc_reg);
        if (!convEnable) begin
            state_next = sdc_pkg::SDC_IDLE;
            period_next = '0;
            bitIdx_next = '0;
            acc_next = '0;
            d3_next = '0;
            d2_next = '0;
            d1_next = '0;
            w_next = '0;
            doneN_next = `SDC_DONE_N_RST;
        end else begin
            unique case (state_reg)
                sdc_pkg::SDC_IDLE: begin
                    state_next = sdc_pkg::SDC_START;
                    period_next = '0;
                end
                sdc_pkg::SDC_START: begin
                    if (period_reg == PW'(`SDC_START_EXTRA - 1)) begin
                        state_next = sdc_pkg::SDC_CONV;
                        period_next = '0;
                    end else begin
                        period_next = period_reg + 1'b1;
                    end
                end
                sdc_pkg::SDC_CONV: begin
                    period_next = period_reg + 1'b1;
                    if (period_reg[1:0] == 2'h3) begin
                        // weight is four cascaded boxcars, so zeros land at rate / segment
                        d3_next = d3_reg + imp_at(bitIdx_reg);
                        d2_next = d2_reg + d3_next;
                        d1_next = d1_reg + d2_next;
                        w_next = w_reg + d1_next;
                        acc_next = modBit ? acc_reg + ACC_W'(w_next) : acc_reg - ACC_W'(w_next);
                        bitIdx_next = bitIdx_reg + 1'b1;
                    end
                    if (period_reg == PW'(CONV_PERIODS - 1)) begin
                        state_next = sdc_pkg::SDC_DONE;
                    end
                end
                sdc_pkg::SDC_DONE: begin
                    if (fifoInReady) begin
                        push = 1'b1;
                        doneN_next = 1'b0;
                        period_next = '0;
                        bitIdx_next = '0;
                        acc_next = '0;
                        d3_next = '0;
                        d2_next = '0;
                        d1_next = '0;
                        w_next = '0;
                        state_next = contMode ? sdc_pkg::SDC_CONV : sdc_pkg::SDC_SLEEP;
                    end
                end
                sdc_pkg::SDC_SLEEP: begin
                    state_next = sdc_pkg::SDC_SLEEP;
                end
                default: begin
                    state_next = sdc_pkg::SDC_IDLE;
                end
            endcase
        end
        modClk_next = (state_next == sdc_pkg::SDC_CONV) && period_next[1];
        busy_next = (state_next == sdc_pkg::SDC_START) || (state_next == sdc_pkg::SDC_CONV)
            || (state_next == sdc_pkg::SDC_DONE);
    end

    // sequencer and filter registers
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            state_reg <= sdc_pkg::SDC_IDLE;
            period_reg <= '0;
            bitIdx_reg <= '0;
            acc_reg <= '0;
            d3_reg <= '0;
            d2_reg <= '0;
            d1_reg <= '0;
            w_reg <= '0;
            doneN_reg <= `SDC_DONE_N_RST;
            modClk_reg <= 1'b0;
            busy_reg <= 1'b0;
        end else begin
            state_reg <= state_next;
            period_reg <= period_next;
            bitIdx_reg <= bitIdx_next;
            acc_reg <= acc_next;
            d3_reg <= d3_next;
            d2_reg <= d2_next;
            d1_reg <= d1_next;
            w_reg <= w_next;
            doneN_reg <= doneN_next;
            modClk_reg <= modClk_next;
            busy_reg <= busy_next;
        end
    end

    // result buffer; the serial side drains it through its own crossing
    sdc_fifo #(
        .WIDTH($bits(sdc_pkg::sdc_word_t)),
        .DEPTH(FIFO_DEPTH)
    ) resultBuf (
        .clk(clk),
        .resetn(resetn),
        .inValid(push),
        .inReady(fifoInReady),
        .inData(word),
        .outValid(resultValid),
        .outReady(resultReady),
        .outData(resultData)
    );

    assign sharedDataDonePinN = doneN_reg;
    assign modClk = modClk_reg;
    assign busy = busy_reg;

    chk_start_extra: assert property (@(posedge clk) disable iff (!resetn)
        (state_reg == sdc_pkg::SDC_START && state_next == sdc_pkg::SDC_CONV)
        |-> period_reg == PW'(`SDC_START_EXTRA - 1))
        else $error("start-up extension has wrong length");
    chk_conv_length: assert property (@(posedge clk) disable iff (!resetn)
        $rose(state_reg == sdc_pkg::SDC_DONE) |-> $past(period_reg) == PW'(CONV_PERIODS - 1))
        else $error("conversion ended at wrong period");
    chk_bits_used: assert property (@(posedge clk) disable iff (!resetn)
        $rose(state_reg == sdc_pkg::SDC_DONE) |-> bitIdx_reg == PW'(NBITS))
        else $error("filter did not take one bit per four periods");
    chk_weight_return: assert property (@(posedge clk) disable iff (!resetn)
        (state_reg == sdc_pkg::SDC_DONE) |-> w_reg == 0 && d1_reg == 0 && d2_reg == 0 && d3_reg == -32'sd1)
        else $error("filter weight did not return to zero");
    chk_ready_flag: assert property (@(posedge clk) disable iff (!resetn)
        push && convEnable |=> !sharedDataDonePinN && acc_reg == 0 ##1 resultValid)
        else $error("ready or clear missing after result");
    chk_shutdown_hold: assert property (@(posedge clk) disable iff (!resetn)
        !convEnable |=> state_reg == sdc_pkg::SDC_IDLE && acc_reg == 0 && !busy)
        else $error("logic ran during shutdown");
    chk_overrange_bits: assert property (@(posedge clk) disable iff (!resetn)
        push |-> !(word.overrange_low_bit && word.overrange_high_bit))
        else $error("both overrange bits set");
    chk_mod_clock: assert property (@(posedge clk) disable iff (!resetn)
        $rose(modClk) |=> modClk ##1 !modClk ##1 !modClk)
        else $error("modulator clock is not rate over four");
endmodule : sdc_conversion_core

// *** design/sdc_map.svh ***
// Purpose: offsets, field positions, reset values and timing counts of the conversion core
// Assumes: clk is the internal conversion oscillator, one edge per internal clock period
// Notes: conversion times are in microseconds and oscillator rates in hertz
`ifndef SDC_MAP_SVH
`define SDC_MAP_SVH

`define SDC_WORD_W 24
`define SDC_CODE_W 22
`define SDC_OVL_BIT 23
`define SDC_OVH_BIT 22
`define SDC_SIGN_BIT 21
`define SDC_BIT_DIV 4
`define SDC_ORDER 4
`define SDC_OSR_FAST 128
`define SDC_START_EXTRA 144
`define SDC_STAGGER_SEG 563
`define SDC_GAIN_NUM 9175
`define SDC_GAIN_SHIFT 13
`define SDC_DONE_N_RST 1'b1

`define SDC_TCONV_US_50 80000
`define SDC_TCONV_US_60 66670
`define SDC_TCONV_US_DUAL 72730
`define SDC_TCONV_US_FAST 16670
`define SDC_OSC_HZ_50 102400
`define SDC_OSC_HZ_60 122880
`define SDC_OSC_HZ_DUAL 112640
`define SDC_OSC_HZ_FAST 122880

// whole internal periods in a conversion, rounded down
`define SDC_PERIODS(us, hz) (((us) * 64'd1 * (hz)) / 64'd1000000)

`endif

// *** design/sdc_pkg.sv ***
// Purpose: types and period arithmetic shared by the conversion core
// Assumes: sdc_map.svh holds every number
// Notes: the variant selects oscillator rate, period count and filter segments
`include "sdc_map.svh"
package sdc_pkg;

    typedef enum logic [1:0] {
        SDC_V50 = 2'b00,
        SDC_V60 = 2'b01,
        SDC_VDUAL = 2'b10,
        SDC_VFAST = 2'b11
    } sdc_variant_t;

    typedef enum logic [2:0] {
        SDC_IDLE = 3'b000,
        SDC_START = 3'b001,
        SDC_CONV = 3'b010,
        SDC_DONE = 3'b011,
        SDC_SLEEP = 3'b100
    } sdc_state_t;

    typedef struct packed {
        logic overrange_low_bit;
        logic overrange_high_bit;
        logic [`SDC_CODE_W-1:0] code;
    } sdc_word_t;

    // internal periods per conversion for a variant, from its oscillator rate
    function automatic int conv_periods(input sdc_variant_t v);
        unique case (v)
            SDC_V50: return int'(`SDC_PERIODS(`SDC_TCONV_US_50, `SDC_OSC_HZ_50));
            SDC_V60: return int'(`SDC_PERIODS(`SDC_TCONV_US_60, `SDC_OSC_HZ_60));
            SDC_VDUAL: return int'(`SDC_PERIODS(`SDC_TCONV_US_DUAL, `SDC_OSC_HZ_DUAL));
            SDC_VFAST: return int'(`SDC_PERIODS(`SDC_TCONV_US_FAST, `SDC_OSC_HZ_FAST));
        endcase
    endfunction : conv_periods

    // boxcar length of filter section k; dual variant alternates two lengths
    function automatic int seg_len(input sdc_variant_t v, input int k, input int nBits);
        if (v == SDC_VDUAL) begin
            return (k % 2 == 0) ? `SDC_STAGGER_SEG : nBits / 2 - `SDC_STAGGER_SEG;
        end
        return nBits / `SDC_ORDER;
    endfunction : seg_len

endpackage : sdc_pkg

// *** sim/sdc_modulator_model.sv ***
// Purpose: stands in for the modulator bit stream and the serial readout side of the core
// Assumes: the bench picks the bit pattern and whether readout stalls
// Notes: bits change on the falling clock edge, after the core has sampled them
`timescale 1ns/1ns
module sdc_modulator_model (
    // clock and reset
    input wire logic clk,
    input wire logic resetn,
    // modulator side
    input wire logic modClk,
    output logic modBit,
    // readout side
    input wire logic resultValid,
    output logic resultReady,
    input wire sdc_pkg::sdc_word_t resultData,
    // bench control and observation
    input wire logic [1:0] pattern,
    input wire logic stall,
    output int bitCount,
    output int takeCount,
    output sdc_pkg::sdc_word_t lastWord
);
    logic modClkPrev;
    logic phase;
    // one new bit per four-period slot, stepped once the slot's clock falls
    always @(negedge clk or negedge resetn) begin
        if (!resetn) begin
            modClkPrev <= 1'b0;
            phase <= 1'b0;
            bitCount <= 0;
            resultReady <= 1'b0;
        end else begin
            modClkPrev <= modClk;
            resultReady <= !stall;
            if (modClk && !modClkPrev) begin
                bitCount <= bitCount + 1;
            end
            if (!modClk && modClkPrev) begin
                phase <= !phase;
            end
        end
    end
    // pattern 0 all low, 1 all high, 2 alternating
    assign modBit = (pattern == 2'd0) ? 1'b0 : (pattern == 2'd1) ? 1'b1 : phase;
    // readout takes a word on any rising edge with valid and ready
    always @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            takeCount <= 0;
            lastWord <= '0;
        end else if (resultValid && resultReady) begin
            takeCount <= takeCount + 1;
            lastWord <= resultData;
        end
    end
endmodule : sdc_modulator_model

// *** sim/sdc_conversion_core_tb_top.sv ***
// Purpose: self-checking bench for the conversion core with a short conversion count
// Assumes: fast variant shortened to 64 periods, so 16 bits per conversion
// Notes: inputs change on the falling edge; outputs are sampled 1 ns after the rising edge
`timescale 1ns/1ns
`include "sdc_map.svh"
module sdc_conversion_core_tb_top;
    localparam int CONV = 64;
    localparam int NBITS = CONV / `SDC_BIT_DIV;
    localparam int DEPTH = 32;
    localparam int FIRST = 1 + `SDC_START_EXTRA + CONV + 1;
    logic clk = 1'b0;
    logic resetn = 1'b0;
    logic convEnable = 1'b0;
    logic contMode = 1'b0;
    logic modBit;
    logic modClk;
    logic sharedDataDonePinN;
    logic busy;
    logic resultValid;
    logic resultReady;
    sdc_pkg::sdc_word_t resultData;
    logic [1:0] pattern = 2'd1;
    logic stall = 1'b1;
    int bitCount;
    int takeCount;
    sdc_pkg::sdc_word_t lastWord;
    int fail_count = 0;
    int n_tests = 0;
    int cycles = 0;
    int n;
    int k;
    // 125 MHz clock
    always #4 clk = !clk;
    sdc_conversion_core #(.VARIANT(sdc_pkg::SDC_VFAST), .CONV_PERIODS(CONV), .FIFO_DEPTH(DEPTH)) i_sdc_conversion_core (
        .clk(clk), .resetn(resetn), .convEnable(convEnable), .contMode(contMode), .modBit(modBit),
        .modClk(modClk), .sharedDataDonePinN(sharedDataDonePinN), .busy(busy), .resultValid(resultValid),
        .resultReady(resultReady), .resultData(resultData));
    sdc_modulator_model i_sdc_modulator_model (
        .clk(clk), .resetn(resetn), .modClk(modClk), .modBit(modBit), .resultValid(resultValid),
        .resultReady(resultReady), .resultData(resultData), .pattern(pattern), .stall(stall),
        .bitCount(bitCount), .takeCount(takeCount), .lastWord(lastWord));
    // compare and count
    task automatic check(input logic [31:0] seen, input logic [31:0] exp, input string what);
        n_tests++;
        if (seen !== exp) begin
            fail_count++;
            $display("Error at %0t: %s seen %h expected %h", $time, what, seen, exp);
        end
    endtask : check
    // verdict and end of run
    task automatic results();
        $display("checks %0d mismatches %0d", n_tests, fail_count);
        if (fail_count == 0 && n_tests > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask : results
    // hang guard
    always @(posedge clk) begin
        cycles <= cycles + 1;
        if (cycles == 12000) begin
            fail_count++;
            results();
        end
    end
    // edges from leaving idle until ready falls
    task automatic time_to_ready(output int t);
        t = 0;
        while (busy !== 1'b1 && t < 10) begin
            @(posedge clk);
            #1;
            t++;
        end
        while (sharedDataDonePinN !== 1'b0 && t < 400) begin
            @(posedge clk);
            #1;
            t++;
        end
    endtask : time_to_ready
    // shutdown, then start a fresh conversion
    task automatic restart(input logic [1:0] pat, input logic cont, input logic hold);
        @(negedge clk);
        convEnable = 1'b0;
        @(posedge clk);
        @(posedge clk);
        #1;
        check(busy, 1'b0, "busy in shutdown");
        check(sharedDataDonePinN, 1'b1, "ready in shutdown");
        check(modClk, 1'b0, "bit clock in shutdown");
        @(negedge clk);
        pattern = pat;
        contMode = cont;
        stall = hold;
        convEnable = 1'b1;
    endtask : restart
    // first single conversion after reset, all-high stream
    task automatic t_first_single();
        k = bitCount;
        @(negedge clk);
        convEnable = 1'b1;
        time_to_ready(n);
        check(n, FIRST, "first conversion length");
        check(bitCount - k, NBITS, "bits per conversion");
        repeat (2) @(posedge clk);
        #1;
        check(resultValid, 1'b1, "word offered");
        check(resultData.overrange_low_bit, 1'b0, "high stream sign");
        check(resultData.overrange_high_bit, 1'b1, "high stream overrange");
        check(resultData.overrange_low_bit & resultData.overrange_high_bit, 1'b0, "both overrange bits");
        check(busy, 1'b0, "single mode sleeps");
        @(negedge clk);
        stall = 1'b0;
        repeat (200) @(posedge clk);
        #1;
        check(takeCount, 1, "single mode one word");
        check(sharedDataDonePinN, 1'b0, "ready stands");
    endtask : t_first_single
    // after shutdown the extension returns; all-low stream is negative
    task automatic t_shutdown_low();
        restart(2'd0, 1'b0, 1'b0);
        time_to_ready(n);
        check(n, FIRST, "extension after shutdown");
        repeat (3) @(posedge clk);
        #1;
        check(takeCount, 2, "second word taken");
        check(lastWord.overrange_high_bit, 1'b0, "low stream high flag");
        check(lastWord.overrange_low_bit | lastWord.code[`SDC_SIGN_BIT], 1'b1, "low stream sign");
    endtask : t_shutdown_low
    // continuous conversions follow without the extension
    task automatic t_continuous();
        restart(2'd2, 1'b1, 1'b0);
        time_to_ready(n);
        check(n, FIRST, "continuous first length");
        k = takeCount;
        n = 0;
        while (takeCount == k && n < 10) begin
            @(posedge clk);
            #1;
            n++;
        end
        k = takeCount;
        n = 0;
        while (takeCount == k && n < 400) begin
            @(posedge clk);
            #1;
            n++;
        end
        check(n, CONV + 1, "back-to-back spacing");
        check({lastWord.overrange_low_bit, lastWord.overrange_high_bit}, 2'b00, "balanced stream in range");
        check(lastWord.code, 32'h0, "balanced stream code");
    endtask : t_continuous
    // fill the buffer until the core stalls, then drain it
    task automatic t_fill_drain();
        @(negedge clk);
        stall = 1'b1;
        repeat ((DEPTH + 4) * (CONV + 1)) @(posedge clk);
        k = takeCount;
        n = 0;
        repeat (8) begin
            @(posedge clk);
            #1;
            n = n + int'(modClk);
        end
        check(n, 0, "no bits while stalled");
        check(busy, 1'b1, "stalled core busy");
        check(resultValid, 1'b1, "buffer holds words");
        @(negedge clk);
        stall = 1'b0;
        repeat (45) @(posedge clk);
        #1;
        check(takeCount - k, DEPTH + 2, "no word lost");
    endtask : t_fill_drain
    // main sequence
    initial begin
        repeat (4) @(posedge clk);
        @(negedge clk);
        resetn = 1'b1;
        #1;
        check(sharedDataDonePinN, 1'b1, "ready after reset");
        t_first_single();
        t_shutdown_low();
        t_continuous();
        t_fill_drain();
        results();
    end
endmodule : sdc_conversion_core_tb_top
